// ==== hw/charger_supervision_pkg.sv ====
// Charger supervision constants, map and types.
// Assumes 40 MHz clk_i, classic Wishbone slave.
package charger_supervision_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int SEC_CYCLES_DEF  = CLK_HZ;
  localparam int FAULT_TIME_MS   = 2500;
  localparam int FAULT_CYCLES_DEF = (CLK_HZ / 1000) * FAULT_TIME_MS;
  localparam int PWM_HZ          = 128;
  localparam int PWM_STEPS       = 255;
  localparam int PWM_STEP_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int WDG_STD_S       = 6 * 60;
  localparam int WDG_OTHER_S     = 14 * 60;
  localparam int WDG_STD_LONG_S  = 11 * 60;
  localparam int WDG_OTHER_LONG_S = 29 * 60;
  localparam int WDG_W           = 11;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] A_CTL1   = 8'h00;
  localparam logic [7:0] A_WDG    = 8'h04;
  localparam logic [7:0] A_SET    = 8'h08;
  localparam logic [7:0] A_LIMIT  = 8'h0c;
  localparam logic [7:0] A_LED    = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_EFFECT = 8'h18;

  // Field positions
  localparam int F_CHG_EN   = 2;
  localparam int F_RESTART  = 7;   // Write only
  localparam int F_VOLT     = 8;
  localparam int F_LOCK     = 16;
  localparam int F_LED_SRC  = 1;
  localparam int F_LED_LVL  = 4;
  localparam int F_LED_DUTY = 8;
  localparam int F_LED_PD   = 16;
  localparam int S_BATT_RM  = 0;
  localparam int S_SHORT    = 1;
  localparam int S_SW_MODE  = 2;
  localparam int S_USB_EN   = 3;
  localparam int S_EXT_EN   = 4;
  localparam int S_WDG_EXP  = 5;
  localparam int S_CHARGING = 6;
  localparam int S_BOOST    = 7;
  localparam int S_FALLEN   = 8;

  // Reset values
  localparam logic [6:0] SW_TO_RST    = 7'h7f;
  localparam logic [3:0] CUR_RST      = 4'h0;
  localparam logic [5:0] VOLT_RST     = 6'h00;
  localparam logic [3:0] LIM_CUR_RST  = 4'hf;
  localparam logic [5:0] LIM_VOLT_RST = 6'h3f;
  localparam logic [1:0] BOOST_OFF    = 2'h0;

  // LED supply codes
  localparam logic [1:0] LED_SRC_MID  = 2'h0;
  localparam logic [1:0] LED_SRC_WALL = 2'h1;
  localparam logic [1:0] LED_SRC_AUX  = 2'h2;

  // Synchronised pin vector indices
  localparam int P_VBUS     = 0;
  localparam int P_WALL     = 1;
  localparam int P_DET_N    = 2;
  localparam int P_EXT_ST_N = 3;
  localparam int P_BATT_HI  = 4;
  localparam int P_SHORT    = 5;
  localparam int P_USB_FLT  = 6;
  localparam int P_EXT_FLT  = 7;
  localparam int P_USB_CHG  = 8;
  localparam int P_ACTIVE   = 9;
  localparam int P_SLEEP    = 10;
  localparam int P_NV_LONG  = 11;
  localparam int P_NV_DEP   = 12;
  localparam int P_NV_INV   = 13;
  localparam int NPIN       = 14;

  typedef enum logic [1:0] {
    PATH_NONE,
    PATH_USB,
    PATH_EXT
  } path_e;

endpackage

// ==== hw/charger_supervision_control.sv ====
// Charger supervision: watchdog, limits, path choice, LED, boost.
// Assumes asynchronous pins from analog comparators and straps, and
// rst_i driven by the power-on reset.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
module charger_supervision_control #(
  parameter int SEC_CYCLES   = charger_supervision_pkg::SEC_CYCLES_DEF,
  parameter int FAULT_CYCLES = charger_supervision_pkg::FAULT_CYCLES_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Pins and comparators
  input  wire logic        vbus_present_i,
  input  wire logic        wall_supply_input_i,
  input  wire logic        charger_type_detect_n_i,
  input  wire logic        ext_charger_status_n_i,
  input  wire logic        battery_sense_input_i,
  input  wire logic        bus_short_i,
  input  wire logic        usb_fault_i,
  input  wire logic        ext_fault_i,
  input  wire logic        usb_charging_i,
  input  wire logic        sys_active_i,
  input  wire logic        sys_sleep_i,
  input  wire logic        nv_long_wdg_i,
  input  wire logic        nv_source_dep_i,
  input  wire logic        nv_detect_invert_i,
  // Controls
  output logic             usb_charge_en_o,
  output logic             ext_charger_enable_n_o,
  output logic      [3:0]  charge_current_o,
  output logic      [5:0]  charge_voltage_o,
  output logic             presence_detect_en_o,
  output logic             battery_removed_o,
  output logic             led_drive_o,
  output logic             led_pulldown_o,
  output logic      [1:0]  led_supply_sel_o,
  output logic      [3:0]  led_current_o,
  output logic             boost_en_o,
  output logic             bus_short_flag_o
);
  import charger_supervision_pkg::*;

  localparam int SW = $clog2(SEC_CYCLES);
  localparam int FW = $clog2(FAULT_CYCLES);
  localparam int PW = $clog2(PWM_STEP_CYCLES);
  localparam logic [SW-1:0] SEC_LAST = SW'(SEC_CYCLES - 1);
  localparam logic [FW-1:0] FLT_LAST = FW'(FAULT_CYCLES - 1);
  localparam logic [PW-1:0] PWM_LAST = PW'(PWM_STEP_CYCLES - 1);
  localparam logic [7:0] SLOT_LAST = 8'(PWM_STEPS - 1);

  typedef struct packed {
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic            ack;
    logic [31:0]     rdata;
    logic [1:0]      boost_sel;
    logic            chg_en;
    logic [6:0]      sw_to;
    logic [3:0]      cur_set;
    logic [5:0]      volt_set;
    logic [3:0]      lim_cur;
    logic [5:0]      lim_volt;
    logic            lock;
    logic            led_sw_en;
    logic [1:0]      led_src;
    logic [3:0]      led_lvl;
    logic [7:0]      led_duty;
    logic            led_pd_sel;
    logic            st_batt_rm;
    logic            st_short;
    logic            sw_mode;
    logic            wdg_exp;
    path_e           path;
    logic            fallen;
    logic [SW-1:0]   sec_cnt;
    logic [WDG_W-1:0] wdg_cnt;
    logic [FW-1:0]   flt_cnt;
    logic [PW-1:0]   pwm_div;
    logic [7:0]      pwm_slot;
    logic            usb_en;
    logic            ext_en_n;
    logic [3:0]      cur_out;
    logic [5:0]      volt_out;
    logic            det_en;
    logic            batt_rm;
    logic            led_drv;
    logic            led_pd;
    logic [1:0]      led_sup;
    logic [3:0]      led_cur;
    logic            boost_en;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [NPIN-1:0] pins;
  assign pins = {nv_detect_invert_i, nv_source_dep_i, nv_long_wdg_i,
                 sys_sleep_i, sys_active_i, usb_charging_i, ext_fault_i,
                 usb_fault_i, bus_short_i, battery_sense_input_i,
                 ext_charger_status_n_i, charger_type_detect_n_i,
                 wall_supply_input_i, vbus_present_i};

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [NPIN-1:0] p;
    logic            acc;
    logic            wr;
    logic            rd_wr_wdg;
    logic            wr_set;
    logic            enter_sw;
    logic            restart;
    logic            sec_tick;
    logic            det_usb;
    logic            both;
    logic            batt_gone;
    logic            charge_ok;
    logic            cur_fault;
    logic            chg_active;
    logic            led_on;
    logic            pwm_on;
    logic [WDG_W-1:0] hw_period;
    path_e           high_p;
    path_e           low_p;
    path_e           pref;
    logic [31:0]     rd;

    st_nxt = st_r;
    p      = st_r.sync2;

    // Two-stage synchroniser for every pin
    st_nxt.sync1 = pins;
    st_nxt.sync2 = st_r.sync1;

    // Classic Wishbone: ack one cycle after strobe, then drop
    acc        = cyc_i && stb_i && !st_r.ack;
    wr         = acc && we_i;
    st_nxt.ack = acc;
    rd_wr_wdg  = wr && (adr_i == A_WDG) && sel_i[0];
    wr_set     = wr && (adr_i == A_SET) && (sel_i[0] || sel_i[1]);
    restart    = rd_wr_wdg && dat_i[F_RESTART];
    enter_sw   = rd_wr_wdg || wr_set;

    // Register writes
    if (wr && (adr_i == A_CTL1) && sel_i[0]) begin
      st_nxt.boost_sel = dat_i[1:0];
      st_nxt.chg_en    = dat_i[F_CHG_EN];
    end
    if (rd_wr_wdg) begin
      st_nxt.sw_to = dat_i[6:0];
    end
    if (wr && (adr_i == A_SET) && sel_i[0]) begin
      st_nxt.cur_set = dat_i[3:0];
    end
    if (wr && (adr_i == A_SET) && sel_i[1]) begin
      st_nxt.volt_set = dat_i[F_VOLT +: 6];
    end
    // Lock makes limits read-only until power-on reset
    if (wr && (adr_i == A_LIMIT) && !st_r.lock) begin
      if (sel_i[0]) begin
        st_nxt.lim_cur = dat_i[3:0];
      end
      if (sel_i[1]) begin
        st_nxt.lim_volt = dat_i[F_VOLT +: 6];
      end
      if (sel_i[2]) begin
        st_nxt.lock = dat_i[F_LOCK];
      end
    end
    if (wr && (adr_i == A_LED)) begin
      if (sel_i[0]) begin
        st_nxt.led_sw_en = dat_i[0];
        st_nxt.led_src   = dat_i[F_LED_SRC +: 2];
        st_nxt.led_lvl   = dat_i[F_LED_LVL +: 4];
      end
      if (sel_i[1]) begin
        st_nxt.led_duty = dat_i[F_LED_DUTY +: 8];
      end
      if (sel_i[2]) begin
        st_nxt.led_pd_sel = dat_i[F_LED_PD];
      end
    end
    // Write-one-to-clear status; a new event below wins
    if (wr && (adr_i == A_STATUS) && sel_i[0]) begin
      if (dat_i[S_BATT_RM]) begin
        st_nxt.st_batt_rm = 1'b0;
      end
      if (dat_i[S_SHORT]) begin
        st_nxt.st_short = 1'b0;
      end
    end
    if (enter_sw) begin
      st_nxt.sw_mode = 1'b1;
    end

    // One-second tick for the watchdog
    sec_tick       = (st_r.sec_cnt == SEC_LAST);
    st_nxt.sec_cnt = sec_tick ? '0 : st_r.sec_cnt + 1'b1;

    // Detect input: high means charging port unless inverted
    det_usb = p[P_DET_N] ^ p[P_NV_INV];
    both    = p[P_VBUS] && p[P_WALL];

    // Path priority and one-way fallback
    high_p = det_usb ? PATH_USB : PATH_EXT;
    low_p  = det_usb ? PATH_EXT : PATH_USB;
    if (both) begin
      pref = st_r.fallen ? low_p : high_p;
    end else if (p[P_VBUS]) begin
      pref = PATH_USB;
    end else if (p[P_WALL]) begin
      pref = PATH_EXT;
    end else begin
      pref = PATH_NONE;
    end
    st_nxt.path = pref;

    // Fault timer only with two chargers; one charger stays on
    unique case (st_r.path)
      PATH_USB: cur_fault = p[P_USB_FLT];
      PATH_EXT: cur_fault = p[P_EXT_FLT];
      default:  cur_fault = 1'b0;
    endcase
    if (!both) begin
      st_nxt.fallen  = 1'b0;
      st_nxt.flt_cnt = '0;
    end else if (cur_fault && !st_r.sw_mode && !st_r.fallen) begin
      st_nxt.flt_cnt = st_r.flt_cnt + 1'b1;
      if (st_r.flt_cnt == FLT_LAST) begin
        st_nxt.fallen = 1'b1;
      end
    end else begin
      st_nxt.flt_cnt = '0;
    end

    // Hardware watchdog period
    if (p[P_NV_DEP] && det_usb && pref == PATH_USB) begin
      hw_period = p[P_NV_LONG] ? WDG_W'(WDG_STD_LONG_S)
                               : WDG_W'(WDG_STD_S);
    end else begin
      hw_period = p[P_NV_LONG] ? WDG_W'(WDG_OTHER_LONG_S)
                               : WDG_W'(WDG_OTHER_S);
    end

    // Watchdog: re-armed on unplug, reloaded by software restart
    if (st_r.path == PATH_NONE) begin
      st_nxt.wdg_exp = 1'b0;
      st_nxt.wdg_cnt = st_r.sw_mode ? WDG_W'(st_r.sw_to) : hw_period;
    end else if (restart || (enter_sw && !st_r.sw_mode)) begin
      st_nxt.wdg_exp = 1'b0;
      st_nxt.wdg_cnt = WDG_W'(dat_i[6:0]);
      if (!rd_wr_wdg) begin
        st_nxt.wdg_cnt = WDG_W'(st_r.sw_to);
      end
    end else if (sec_tick && !st_r.wdg_exp) begin
      if (st_r.wdg_cnt <= WDG_W'(1)) begin
        st_nxt.wdg_exp = 1'b1;
        st_nxt.wdg_cnt = '0;
      end else begin
        st_nxt.wdg_cnt = st_r.wdg_cnt - 1'b1;
      end
    end

    // Battery removal seen only while the detector runs
    batt_gone = st_r.det_en && p[P_BATT_HI];
    if (batt_gone) begin
      st_nxt.st_batt_rm = 1'b1;
    end
    st_nxt.batt_rm = batt_gone;

    charge_ok = (st_r.path != PATH_NONE) && !batt_gone &&
                !st_r.st_batt_rm && !st_r.wdg_exp && st_r.chg_en;
    st_nxt.usb_en   = charge_ok && (pref == PATH_USB);
    st_nxt.ext_en_n = !(charge_ok && (pref == PATH_EXT));
    st_nxt.det_en   = charge_ok || p[P_ACTIVE] || p[P_SLEEP];

    // Clamp requested settings to the limit registers
    st_nxt.cur_out  = (st_r.cur_set > st_r.lim_cur) ?
                      st_r.lim_cur : st_r.cur_set;
    st_nxt.volt_out = (st_r.volt_set > st_r.lim_volt) ?
                      st_r.lim_volt : st_r.volt_set;

    // PWM: 255 slots per 128 Hz period
    if (st_r.pwm_div == PWM_LAST) begin
      st_nxt.pwm_div  = '0;
      st_nxt.pwm_slot = (st_r.pwm_slot == SLOT_LAST) ?
                        8'h00 : st_r.pwm_slot + 8'h01;
    end else begin
      st_nxt.pwm_div = st_r.pwm_div + 1'b1;
    end
    pwm_on = (st_r.pwm_slot < st_r.led_duty);

    // LED follows real charging in hardware mode
    chg_active = (st_r.usb_en && p[P_USB_CHG]) ||
                 (!st_r.ext_en_n && !p[P_EXT_ST_N]);
    if (st_r.sw_mode) begin
      led_on         = st_r.led_sw_en;
      st_nxt.led_drv = led_on && pwm_on;
      st_nxt.led_sup = st_r.led_src;
      st_nxt.led_cur = st_r.led_lvl;
    end else begin
      led_on         = chg_active;
      st_nxt.led_drv = led_on;
      st_nxt.led_sup = (st_r.path == PATH_EXT) ?
                       LED_SRC_WALL : LED_SRC_MID;
      st_nxt.led_cur = st_r.led_lvl;
    end
    st_nxt.led_pd = !led_on && st_r.led_pd_sel;

    // Boost stops on a bus short until software clears the flag
    if (st_r.boost_en && p[P_SHORT]) begin
      st_nxt.st_short = 1'b1;
    end
    st_nxt.boost_en = (st_r.boost_sel != BOOST_OFF) &&
                      !st_r.st_short && !st_nxt.st_short && !p[P_SHORT];

    // Read mux; unmapped reads return zero
    rd = 32'h0000_0000;
    unique case (adr_i)
      A_CTL1: begin
        rd[1:0]      = st_r.boost_sel;
        rd[F_CHG_EN] = st_r.chg_en;
      end
      A_WDG: rd[6:0] = st_r.sw_to;
      A_SET: begin
        rd[3:0]        = st_r.cur_set;
        rd[F_VOLT +: 6] = st_r.volt_set;
      end
      A_LIMIT: begin
        rd[3:0]         = st_r.lim_cur;
        rd[F_VOLT +: 6] = st_r.lim_volt;
        rd[F_LOCK]      = st_r.lock;
      end
      A_LED: begin
        rd[0]               = st_r.led_sw_en;
        rd[F_LED_SRC +: 2]  = st_r.led_src;
        rd[F_LED_LVL +: 4]  = st_r.led_lvl;
        rd[F_LED_DUTY +: 8] = st_r.led_duty;
        rd[F_LED_PD]        = st_r.led_pd_sel;
      end
      A_STATUS: begin
        rd[S_BATT_RM]  = st_r.st_batt_rm;
        rd[S_SHORT]    = st_r.st_short;
        rd[S_SW_MODE]  = st_r.sw_mode;
        rd[S_USB_EN]   = st_r.usb_en;
        rd[S_EXT_EN]   = !st_r.ext_en_n;
        rd[S_WDG_EXP]  = st_r.wdg_exp;
        rd[S_CHARGING] = chg_active;
        rd[S_BOOST]    = st_r.boost_en;
        rd[S_FALLEN]   = st_r.fallen;
      end
      A_EFFECT: begin
        rd[3:0]         = st_r.cur_out;
        rd[F_VOLT +: 6] = st_r.volt_out;
      end
      default: rd = 32'h0000_0000;
    endcase
    st_nxt.rdata = acc ? rd : st_r.rdata;
  end

  // ==========================================================
  // State register; power-on reset sets limits to maximum and clears lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r            <= '0;
      st_r.chg_en     <= 1'b1;
      st_r.sw_to      <= SW_TO_RST;
      st_r.cur_set    <= CUR_RST;
      st_r.volt_set   <= VOLT_RST;
      st_r.lim_cur    <= LIM_CUR_RST;
      st_r.lim_volt   <= LIM_VOLT_RST;
      st_r.lock       <= 1'b0;
      st_r.led_pd_sel <= 1'b1;
      st_r.led_pd     <= 1'b1;
      st_r.ext_en_n   <= 1'b1;
      st_r.path       <= PATH_NONE;
      st_r.boost_sel  <= BOOST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign dat_o = st_r.rdata;
  assign ack_o = st_r.ack;
  assign usb_charge_en_o = st_r.usb_en;
  assign ext_charger_enable_n_o = st_r.ext_en_n;
  assign charge_current_o = st_r.cur_out;
  assign charge_voltage_o = st_r.volt_out;
  assign presence_detect_en_o = st_r.det_en;
  assign battery_removed_o = st_r.st_batt_rm;
  assign led_drive_o = st_r.led_drv;
  assign led_pulldown_o = st_r.led_pd;
  assign led_supply_sel_o = st_r.led_sup;
  assign led_current_o = st_r.led_cur;
  assign boost_en_o = st_r.boost_en;
  assign bus_short_flag_o = st_r.st_short;

endmodule

// ==== verification/charger_supervision_checker.sv ====
// Port assertions and covers for the charger supervision block.
// Assumes two-flop pin synchronisers and registered outputs.
module charger_supervision_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic vbus_present_i,
  input wire logic wall_supply_input_i,
  input wire logic battery_sense_input_i,
  input wire logic bus_short_i,
  input wire logic sys_active_i,
  input wire logic sys_sleep_i,
  input wire logic usb_charge_en_o,
  input wire logic ext_charger_enable_n_o,
  input wire logic presence_detect_en_o,
  input wire logic battery_removed_o,
  input wire logic led_drive_o,
  input wire logic led_pulldown_o,
  input wire logic boost_en_o,
  input wire logic bus_short_flag_o
);
  // ==========================================================
  // Clocking; six samples cover pin sync plus output register
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Paths, removal, presence, LED, boost
  a_one_path: assert property (
    !(usb_charge_en_o && !ext_charger_enable_n_o))
    else $error("two paths on");
  a_usb_needs_bus: assert property (
    (!vbus_present_i)[*6] |-> !usb_charge_en_o)
    else $error("usb on, no bus");
  a_ext_needs_wall: assert property (
    (!wall_supply_input_i)[*6] |-> ext_charger_enable_n_o)
    else $error("ext on, no wall");
  a_batt_removed: assert property (
    battery_sense_input_i[*6] |->
      battery_removed_o && !usb_charge_en_o && ext_charger_enable_n_o)
    else $error("removal missed");
  a_presence_on: assert property (
    (sys_active_i || sys_sleep_i)[*6] |-> presence_detect_en_o)
    else $error("presence off");
  a_pulldown_idle: assert property (
    led_pulldown_o |-> !led_drive_o)
    else $error("pulldown while driven");
  a_short_stop: assert property (
    (boost_en_o && bus_short_i)[*5] |=> !boost_en_o)
    else $error("boost into short");
  a_short_hold: assert property (
    bus_short_flag_o |=> !boost_en_o)
    else $error("boost with short flag");

  // Main scenarios reached
  c_ext_on: cover property ($fell(ext_charger_enable_n_o));
  c_short: cover property ($rose(bus_short_flag_o));
  c_removed: cover property ($rose(battery_removed_o));
endmodule

bind charger_supervision_control charger_supervision_checker chk (.*);

// ==== verification/charger_far_side.sv ====
// Far side model: external charger IC, type detector, USB stage.
// Assumes the bench sets port type, polarity strap and pace.
module charger_far_side (
  input  wire logic clk_i,
  input  wire logic ext_charger_enable_n_i,
  input  wire logic usb_charge_en_i,
  input  wire logic port_475_i,
  input  wire logic invert_i,
  input  wire logic slow_i,
  output logic      ext_charger_status_n_o,
  output logic      charger_type_detect_n_o,
  output logic      usb_charging_o
);
  logic [3:0] ext_q = 4'h0;
  logic [3:0] usb_q = 4'h0;

  // Enable history; slow pace answers four cycles late
  always_ff @(posedge clk_i) begin
    ext_q <= {ext_q[2:0], !ext_charger_enable_n_i};
    usb_q <= {usb_q[2:0], usb_charge_en_i};
  end
  // Open drain status: low only while charging, pull-up otherwise
  assign ext_charger_status_n_o = !(slow_i ? ext_q[3] : ext_q[0]);
  assign usb_charging_o = slow_i ? usb_q[3] : usb_q[0];
  // High means charging port unless the strap inverts it
  assign charger_type_detect_n_o = port_475_i ^ invert_i;
endmodule

// ==== verification/charger_supervision_control_test.sv ====
// Bench for the charger supervision block: bus tasks and tests.
// Assumes the far side model and shortened second and fault counts.
module charger_supervision_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import charger_supervision_pkg::*;

  // ==========================================================
  // Signals and tables
  localparam int SEC = 20;
  localparam int FLT = 50;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, q;
  logic [3:0]  sel_i, charge_current_o, led_current_o;
  logic [5:0]  charge_voltage_o;
  logic [1:0]  led_supply_sel_o;
  logic        we_i, cyc_i, stb_i, ack_o, port, slow;
  logic        vbus_present_i, wall_supply_input_i, bus_short_i;
  logic        charger_type_detect_n_i, ext_charger_status_n_i;
  logic        battery_sense_input_i, usb_fault_i, ext_fault_i;
  logic        usb_charging_i, sys_active_i, sys_sleep_i, nv_long_wdg_i;
  logic        nv_source_dep_i, nv_detect_invert_i, usb_charge_en_o;
  logic        ext_charger_enable_n_o, presence_detect_en_o, boost_en_o;
  logic        battery_removed_o, led_drive_o, led_pulldown_o;
  logic        bus_short_flag_o;
  int          err_count = 0;
  int          checks_done = 0;
  // Rows: bus, wall, port, invert, usb on, ext enable_n
  logic [5:0]  path[6] = '{6'h23, 6'h18, 6'h3b, 6'h30, 6'h3f, 6'h34};
  logic [1:0]  wcfg[3] = '{2'b10, 2'b00, 2'b11};
  int          wmin[3] = '{6, 14, 11};

`define cmp_eq(n, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
    end \
  end

  charger_supervision_control #(.SEC_CYCLES(SEC), .FAULT_CYCLES(FLT)) uut (.*);

  charger_far_side far (
    .clk_i, .ext_charger_enable_n_i(ext_charger_enable_n_o),
    .usb_charge_en_i(usb_charge_en_o), .port_475_i(port),
    .invert_i(nv_detect_invert_i), .slow_i(slow),
    .ext_charger_status_n_o(ext_charger_status_n_i),
    .charger_type_detect_n_o(charger_type_detect_n_i),
    .usb_charging_o(usb_charging_i));

  // ==========================================================
  // Clock, tasks, watchdog
  always #12.5 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle: hold until ack is sampled, then a cycle idle
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d, output logic [31:0] r);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    repeat (50) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (ack_o !== 1'b1) err_count++;
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(a, 1'b0, 32'h0, r);
  endtask

  task automatic supply(input logic [1:0] v);
    vbus_present_i <= v[1];
    wall_supply_input_i <= v[0];
  endtask

  // Cycles USB charging stays on, within one second plus eight cycles of expected
  task automatic on_time(input int e);
    int n;
    n = 0;
    while (usb_charge_en_o !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    n = 0;
    while (usb_charge_en_o === 1'b1 && n < e + 3 * SEC) begin
      tick(1);
      n++;
    end
    `cmp_eq("wdg_span", 1'b1, (n > e - SEC - 8) && (n < e + SEC + 8))
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard sized above the three hardware watchdog spans
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    summarize();
  end

  // ==========================================================
  // Tests
  initial begin
    {adr_i, dat_i, we_i, cyc_i, stb_i, port, slow} = '0;
    sel_i = 4'hf;
    {vbus_present_i, wall_supply_input_i, bus_short_i} = '0;
    {battery_sense_input_i, usb_fault_i, ext_fault_i} = '0;
    {sys_active_i, sys_sleep_i, nv_long_wdg_i, nv_detect_invert_i} = '0;
    nv_source_dep_i = 1'b1;
    tick(12);
    `cmp_eq("ext_en_n", 1'b1, ext_charger_enable_n_o)
    `cmp_eq("led_pd", 1'b1, led_pulldown_o)
    rst_i <= 1'b0;
    tick(1);
    rd(A_LIMIT, q);
    `cmp_eq("lim_rst", 32'h3f0f, q)
    rd(8'h1c, q);
    `cmp_eq("unmapped", 32'h0, q)
    wr(A_LIMIT, 32'h12005);
    wr(A_LIMIT, 32'h3f0f);
    rd(A_LIMIT, q);
    `cmp_eq("lim_lock", 32'h12005, q)
    wr(A_SET, 32'h300a);
    rd(A_EFFECT, q);
    `cmp_eq("effect", 32'h2005, q)
    `cmp_eq("cur_o", 4'h5, charge_current_o)
    `cmp_eq("volt_o", 6'h20, charge_voltage_o)
    rd(A_STATUS, q);
    `cmp_eq("sw_mode", 1'b1, q[S_SW_MODE])
    wr(A_SET, 32'h1003);
    rd(A_EFFECT, q);
    `cmp_eq("effect_lo", 32'h1003, q)
    for (int s = 0; s < 3; s++) begin
      wr(A_LED, 32'h1ff01 | (s << 1) | ((s + 5) << 4));
      `cmp_eq("led_src", s[1:0], led_supply_sel_o)
      `cmp_eq("led_lvl", 4'(s + 5), led_current_o)
      `cmp_eq("led_full", 1'b1, led_drive_o)
    end
    wr(A_LED, 32'h1);
    `cmp_eq("led_duty0", 1'b0, led_drive_o)
    wr(A_LED, 32'h10000);
    `cmp_eq("led_pd_on", 1'b1, led_pulldown_o)
    wr(A_LED, 32'h0);
    `cmp_eq("led_pd_off", 1'b0, led_pulldown_o)
    // Servicing keeps charging alive; silence lets it expire
    supply(2'b10);
    port <= 1'b1;
    tick(10);
    repeat (3) begin
      wr(A_WDG, 32'h83);
      tick(25);
      `cmp_eq("sw_chg", 1'b1, usb_charge_en_o)
    end
    wr(A_WDG, 32'h83);
    on_time(3 * SEC);
    rd(A_STATUS, q);
    `cmp_eq("wdg_exp", 1'b1, q[S_WDG_EXP])
    supply(2'b00);
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rd(A_LIMIT, q);
    `cmp_eq("lim_clr", 32'h3f0f, q)
    rd(A_STATUS, q);
    `cmp_eq("hw_mode", 1'b0, q[S_SW_MODE])
    for (int i = 0; i < 6; i++) begin
      supply(2'b00);
      nv_detect_invert_i <= path[i][2];
      slow <= i[0];
      tick(8);
      {vbus_present_i, wall_supply_input_i, port} <= path[i][5:3];
      tick(16);
      `cmp_eq("usb_en", path[i][1], usb_charge_en_o)
      `cmp_eq("ext_en_n", path[i][0], ext_charger_enable_n_o)
      `cmp_eq("led_chg", 1'b1, led_drive_o)
    end
    supply(2'b00);
    {slow, nv_detect_invert_i, port} <= 3'b001;
    tick(16);
    `cmp_eq("led_off", 1'b0, led_drive_o)
    // Short fault is tolerated, lasting one moves to the wall path
    supply(2'b11);
    tick(10);
    usb_fault_i <= 1'b1;
    tick(FLT - 15);
    usb_fault_i <= 1'b0;
    tick(10);
    `cmp_eq("fb_early", 1'b1, usb_charge_en_o)
    usb_fault_i <= 1'b1;
    tick(FLT + 12);
    `cmp_eq("fb_ext", 1'b0, ext_charger_enable_n_o)
    usb_fault_i <= 1'b0;
    tick(FLT + 12);
    `cmp_eq("fb_stay", 1'b0, usb_charge_en_o)
    rd(A_STATUS, q);
    `cmp_eq("fb_flag", 1'b1, q[S_FALLEN])
    supply(2'b00);
    tick(8);
    supply(2'b10);
    usb_fault_i <= 1'b1;
    tick(3 * FLT);
    `cmp_eq("one_usb", 1'b1, usb_charge_en_o)
    {usb_fault_i, ext_fault_i} <= 2'b01;
    supply(2'b00);
    tick(8);
    supply(2'b01);
    tick(3 * FLT);
    `cmp_eq("one_ext", 1'b0, ext_charger_enable_n_o)
    ext_fault_i <= 1'b0;
    battery_sense_input_i <= 1'b1;
    tick(8);
    `cmp_eq("rm_flag", 1'b1, battery_removed_o)
    `cmp_eq("rm_stop", 1'b1, ext_charger_enable_n_o)
    battery_sense_input_i <= 1'b0;
    tick(4);
    wr(A_STATUS, 32'h1);
    `cmp_eq("rm_clr", 1'b0, battery_removed_o)
    supply(2'b00);
    for (int i = 0; i < 3; i++) begin
      {vbus_present_i, sys_active_i, sys_sleep_i} <= 3'b100 >> i;
      tick(10);
      `cmp_eq("presence", 1'b1, presence_detect_en_o)
    end
    for (int b = 1; b < 4; b++) begin
      wr(A_CTL1, 32'h4 | b);
      `cmp_eq("boost_on", 1'b1, boost_en_o)
    end
    bus_short_i <= 1'b1;
    tick(8);
    `cmp_eq("short_off", 1'b0, boost_en_o)
    `cmp_eq("short_flag", 1'b1, bus_short_flag_o)
    bus_short_i <= 1'b0;
    tick(4);
    `cmp_eq("short_hold", 1'b0, boost_en_o)
    wr(A_STATUS, 32'h2);
    tick(2);
    `cmp_eq("boost_back", 1'b1, boost_en_o)
    wr(A_CTL1, 32'h4);
    `cmp_eq("boost_off", 1'b0, boost_en_o)
    sys_sleep_i <= 1'b0;
    // Hardware spans: charging port, no dependency, long strap
    for (int i = 0; i < 3; i++) begin
      supply(2'b00);
      {nv_source_dep_i, nv_long_wdg_i} <= wcfg[i];
      tick(8);
      supply(2'b10);
      on_time(wmin[i] * 60 * SEC);
      tick(8);
      `cmp_eq("led_idle", 1'b0, led_drive_o)
    end
    summarize();
  end
endmodule
